/* File: common/acs_crc_if.sv */
// Bit feed into the checksum engine and its two running results.
// Assumes: driver and engine sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface acs_crc_if;
  logic       clr;
  logic       seed;
  logic       en;
  logic       bt;
  logic [7:0] poly;
  logic [7:0] xsum;
  modport user (output clr, output seed, output en, output bt, input poly, input xsum);
  modport eng  (input clr, input seed, input en, input bt, output poly, output xsum);
endinterface
`default_nettype wire

/* File: common/acs_pkg.sv */
// Constants and types shared by the serial port, calibration and checksum logic.
// Assumes: compiled before every other file of the block.
package acs_pkg;
  // Calibration coefficients and output scaling
  localparam logic [23:0] OFFS_RST    = 24'h800000;
  localparam logic [23:0] GAIN_RST    = 24'h555555;
  localparam logic [23:0] MID_SCALE   = 24'h800000;
  localparam int          SHIFT_UNI   = 21;
  localparam int          SHIFT_BIP   = 22;
  localparam int          DIV_STEPS   = 46;
  // Checksum polynomial without its top term, and the implied read command
  localparam logic [7:0]  CRC_POLY    = 8'h07;
  localparam logic [7:0]  CMD_RD_DATA = 8'h44;
  localparam int          CMD_RD_BIT  = 6;
  // Register addresses carried in the command byte
  localparam logic [5:0]  A_STAT      = 6'h00;
  localparam logic [5:0]  A_MODE      = 6'h01;
  localparam logic [5:0]  A_IFM       = 6'h02;
  localparam logic [5:0]  A_DATA      = 6'h04;
  localparam logic [5:0]  A_OFFS      = 6'h30;
  localparam logic [5:0]  A_GAIN      = 6'h38;
  // Field positions
  localparam int          STAT_RDY     = 7;
  localparam int          STAT_CRC     = 6;
  localparam int          IFM_CONTREAD = 7;
  localparam int          IFM_CRC_LSB  = 2;
  // Operating modes and checksum selections
  localparam logic [2:0]  MODE_CONT   = 3'h0;
  localparam logic [2:0]  MODE_SINGLE = 3'h1;
  localparam logic [2:0]  MODE_STBY   = 3'h2;
  localparam logic [1:0]  CRC_OFF     = 2'h0;
  localparam logic [1:0]  CRC_XOR     = 2'h1;
  // Serial clocks with data in high that reset the port
  localparam logic [6:0]  RST_ONES    = 7'h40;

  typedef enum logic [2:0] {
    P_CMD  = 3'b000,
    P_WR   = 3'b001,
    P_WCRC = 3'b010,
    P_RD   = 3'b011,
    P_RCRC = 3'b100,
    P_CRD  = 3'b101
  } acs_port_e;

  typedef enum logic [1:0] {
    CAL_NONE = 2'b00,
    CAL_IZS  = 2'b01,
    CAL_SZS  = 2'b10,
    CAL_SFS  = 2'b11
  } acs_cal_e;

  // One message bit into the checksum, most significant bit first
  function automatic logic [7:0] acs_crc_bit(input logic [7:0] c, input logic b);
    return {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] acs_crc_byte(input logic [7:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      c = acs_crc_bit(c, v[i]);
    end
    return c;
  endfunction
endpackage

/* File: src/acs_crc.sv */
// Running polynomial and bytewise exclusive-or checksums over a bit stream.
// Assumes: message lengths are whole bytes; clear has priority over seed and feed.
`timescale 1ns/1ps
`default_nettype none
module acs_crc
  import acs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  acs_crc_if.eng    c
);
  typedef struct packed {
    logic [7:0] poly;
    logic [7:0] xsum;
    logic [7:0] byte_sh;
    logic [2:0] nbit;
  } acs_crc_s;

  acs_crc_s q;
  acs_crc_s d;

  // Both sums run side by side so the caller picks one at the end
  always_comb begin
    d = q;
    if (c.clr) begin
      d = '0;
    end else if (c.seed) begin
      d.poly    = acs_crc_byte(CMD_RD_DATA);
      d.xsum    = CMD_RD_DATA;
      d.byte_sh = 8'h00;
      d.nbit    = 3'h0;
    end else if (c.en) begin
      d.poly    = acs_crc_bit(q.poly, c.bt);
      d.byte_sh = {q.byte_sh[6:0], c.bt};
      d.nbit    = q.nbit + 3'h1;
      if (q.nbit == 3'h7) begin
        d.xsum = q.xsum ^ {q.byte_sh[6:0], c.bt};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign c.poly = q.poly;
  assign c.xsum = q.xsum;
endmodule // acs_crc
`default_nettype wire

/* File: src/acs_top.sv */
// Serial host port of a converter with coefficient calibration and checksums.
// Assumes: a filter supplies raw codes with a one-cycle valid; SPI pins are asynchronous.
//
// What this block does
// - three calibrations: internal zero, system zero, full
// - one channel during calibration; results scaled
// - offset resets 800000, gain nominal 555555
// - unipolar result: corrected code times gain, doubled
// - bipolar result: corrected code times gain, plus midscale
// - calibration end updates coefficient, ready, standby
// - internal zero shorts inputs to negative pin
// - calibration lasts one filter settling time
// - coefficients locked during internal calibration
// - ready low on new result, high after read
// - ready rises before result register update
// - repeated reads; continuous read once only
// - three-wire use with chip select low
// - sixty-four ones reset port and registers
// - writes checked by polynomial, fault flag
// - checksum select: off, polynomial or XOR
// - checksum byte follows command and data
// - continuous read checksum includes implied 0x44
// - polynomial remainder, MSB first, 100000111
// - XOR checksum of all covered bytes
// - fault flag clears on status read
`timescale 1ns/1ps
`default_nettype none
module acs_top
  import acs_pkg::*;
#(
  parameter logic [2:0] CAL_INT_ZS = 3'h4,
  parameter logic [2:0] CAL_SYS_ZS = 3'h5,
  parameter logic [2:0] CAL_SYS_FS = 3'h6
)(
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        SCLK,
  input  wire logic        CS_N,
  input  wire logic        DIN,
  output logic             DOUT_RDY,
  output logic             DOUT_OE,
  input  wire logic        BIPOLAR,
  input  wire logic        CHAN_ONE,
  input  wire logic        CONV_VALID,
  input  wire logic [23:0] CONV_RAW,
  output logic             CONV_RUN,
  output logic             IN_SHORT,
  output logic             CRC_FAULT
);
  typedef struct packed {
    logic [2:0]  sclk_s;
    logic [2:0]  cs_s;
    logic [2:0]  din_s;
    logic        cs_lo;
    acs_port_e   st;
    logic [7:0]  cmd;
    logic [31:0] sh;
    logic [5:0]  cnt;
    logic [6:0]  ones;
    logic        dout;
    logic        rdy_n;
    logic        upd_pend;
    logic [23:0] raw;
    logic [23:0] data;
    logic [23:0] offs;
    logic [23:0] gain;
    logic [2:0]  mode;
    logic [1:0]  crc_sel;
    logic        contread;
    logic        crc_err;
    acs_cal_e    cal;
    logic        div_run;
    logic [5:0]  div_i;
    logic [25:0] den;
    logic [25:0] rem;
    logic [23:0] quo;
    logic        ovf;
  } acs_top_s;

  // Power-on contents, also restored by the serial reset
  function automatic acs_top_s acs_init();
    acs_top_s s;
    s       = '0;
    s.st    = P_CMD;
    s.rdy_n = 1'b1;
    s.dout  = 1'b1;
    // Samplers start at the idle levels, else a false clock rise follows reset
    s.sclk_s = '1;
    s.cs_s   = '1;
    s.offs  = OFFS_RST;
    s.gain  = GAIN_RST;
    s.mode  = MODE_CONT;
    s.cal   = CAL_NONE;
    return s;
  endfunction

  localparam acs_top_s ST_INIT = acs_init();

  // Payload bits that follow the command byte for each register
  function automatic logic [5:0] acs_len(input logic [5:0] a);
    case (a)
      A_MODE, A_IFM:          return 6'h10;
      A_DATA, A_OFFS, A_GAIN: return 6'h18;
      default:                return 6'h08;
    endcase
  endfunction

  // Register contents left-aligned for shifting out
  function automatic logic [31:0] acs_rd_val(input acs_top_s s, input logic [5:0] a);
    logic [7:0]  st8;
    logic [15:0] ifm;
    st8                      = 8'h00;
    ifm                      = 16'h0000;
    st8[STAT_RDY]            = s.rdy_n;
    st8[STAT_CRC]            = s.crc_err;
    ifm[IFM_CONTREAD]        = s.contread;
    ifm[IFM_CRC_LSB +: 2]    = s.crc_sel;
    case (a)
      A_STAT:  return {st8, 24'h000000};
      A_MODE:  return {13'h0000, s.mode, 16'h0000};
      A_IFM:   return {ifm, 16'h0000};
      A_DATA:  return {s.data, 8'h00};
      A_OFFS:  return {s.offs, 8'h00};
      A_GAIN:  return {s.gain, 8'h00};
      default: return 32'h00000000;
    endcase
  endfunction

  // Input code less the offset error; bipolar codes are two's complement
  function automatic logic signed [25:0] acs_corr(input logic [23:0] raw,
                                                  input logic [23:0] off,
                                                  input logic        bip);
    logic [25:0] r;
    r = bip ? {{2{raw[23]}}, raw} : {2'b00, raw};
    return r - ({2'b00, off} - {2'b00, MID_SCALE});
  endfunction

  // Gain scaling and clamping to the 24-bit result range
  function automatic logic [23:0] acs_scale(input logic signed [25:0] corr,
                                            input logic [23:0]        gain,
                                            input logic               bip);
    logic signed [50:0] p;
    p = corr * $signed({1'b0, gain});
    if (bip) begin
      p = (p >>> SHIFT_BIP) + $signed({27'h0000000, MID_SCALE});
    end else begin
      p = p >>> SHIFT_UNI;
    end
    if (p < 0) begin
      return 24'h000000;
    end else if (p > $signed({27'h0000000, 24'hFFFFFF})) begin
      return 24'hFFFFFF;
    end
    return p[23:0];
  endfunction

  acs_top_s           q;
  acs_top_s           d;
  logic               rise;
  logic               fall;
  logic               din_b;
  logic [7:0]         nb;
  logic [5:0]         len;
  logic [23:0]        wv;
  logic               do_wr;
  logic               fin_rd;
  logic               go_idle;
  logic               cal_done;
  logic               qb;
  logic [25:0]        rem_t;
  logic signed [25:0] corr;
  logic               c_clr;
  logic               c_seed;
  logic               c_en;
  logic               c_bt;

  acs_crc_if crc ();

  acs_crc u_crc (
    .clk (CORE_CLK),
    .rst (RST),
    .c   (crc.eng)
  );

  assign crc.clr  = c_clr;
  assign crc.seed = c_seed;
  assign crc.en   = c_en;
  assign crc.bt   = c_bt;

  // Whole next state: serial port, then results, then calibration
  always_comb begin
    d        = q;
    rise     = q.sclk_s[1] & ~q.sclk_s[2];
    fall     = ~q.sclk_s[1] & q.sclk_s[2];
    din_b    = q.din_s[2];
    nb       = {q.cmd[6:0], din_b};
    len      = acs_len(q.cmd[5:0]);
    wv       = q.sh[23:0];
    do_wr    = 1'b0;
    fin_rd   = 1'b0;
    go_idle  = 1'b0;
    cal_done = 1'b0;
    qb       = 1'b0;
    rem_t    = 26'h0000000;
    corr     = 26'sh0000000;
    c_clr    = 1'b0;
    c_seed   = 1'b0;
    c_en     = 1'b0;
    c_bt     = 1'b0;

    // Deselect aborts any frame; with chip select tied low frames just chain
    if (!q.cs_lo) begin
      go_idle = 1'b1;
      d.ones  = 7'h00;
    end else begin
      if (rise) begin
        d.ones = din_b ? q.ones + 7'h01 : 7'h00;
      end
      case (q.st)
        P_CRD: begin
          if (rise) begin
            // Host clocks in a command; only the data read is honoured
            d.cmd = nb;
            d.cnt = 6'h01;
            d.st  = P_CMD;
            c_en  = 1'b1;
            c_bt  = din_b;
          end else if (!q.rdy_n && !q.upd_pend) begin
            // Fresh result goes out once; a read raises ready so it is not resent
            d.sh   = {q.data, 8'h00};
            d.cmd  = CMD_RD_DATA;
            d.cnt  = 6'h00;
            d.st   = P_RD;
            c_seed = 1'b1;
          end
        end
        P_CMD: begin
          if (rise) begin
            d.cmd = nb;
            d.cnt = q.cnt + 6'h01;
            c_en  = 1'b1;
            c_bt  = din_b;
            if (q.cnt == 6'h07) begin
              d.cnt = 6'h00;
              if (q.contread && nb != CMD_RD_DATA) begin
                go_idle = 1'b1;
              end else if (nb[CMD_RD_BIT]) begin
                d.contread = 1'b0;
                d.sh       = acs_rd_val(q, nb[5:0]);
                d.st       = P_RD;
              end else begin
                d.st = P_WR;
              end
            end
          end
        end
        P_WR: begin
          if (rise) begin
            d.sh  = {q.sh[30:0], din_b};
            d.cnt = q.cnt + 6'h01;
            c_en  = 1'b1;
            c_bt  = din_b;
            if (q.cnt == len - 6'h01) begin
              d.cnt = 6'h00;
              if (q.crc_sel == CRC_OFF) begin
                do_wr   = 1'b1;
                wv      = {q.sh[22:0], din_b};
                go_idle = 1'b1;
              end else begin
                d.st = P_WCRC;
              end
            end
          end
        end
        P_WCRC: begin
          if (rise) begin
            d.sh  = {q.sh[30:0], din_b};
            d.cnt = q.cnt + 6'h01;
            if (q.cnt == 6'h07) begin
              // Writes are always checked with the polynomial sum
              if ({q.sh[6:0], din_b} != crc.poly) begin
                d.crc_err = 1'b1;
              end else begin
                do_wr = 1'b1;
                wv    = q.sh[30:7];
              end
              go_idle = 1'b1;
            end
          end
        end
        P_RD, P_RCRC: begin
          // Output changes after a falling edge so the host samples on rising
          if (fall) begin
            d.dout = q.sh[31];
            d.sh   = {q.sh[30:0], 1'b0};
            c_en   = (q.st == P_RD);
            c_bt   = q.sh[31];
          end
          if (rise) begin
            d.cnt = q.cnt + 6'h01;
            if (q.st == P_RCRC) begin
              fin_rd = (q.cnt == 6'h07);
            end else if (q.cnt == len - 6'h01) begin
              d.cnt = 6'h00;
              if (q.crc_sel == CRC_OFF) begin
                fin_rd = 1'b1;
              end else begin
                d.st = P_RCRC;
                d.sh = {(q.crc_sel == CRC_XOR) ? crc.xsum : crc.poly, 24'h000000};
              end
            end
          end
        end
        default: begin
          go_idle = 1'b1;
        end
      endcase
    end

    // End of a read: data read frees the ready line, status read clears the fault
    if (fin_rd) begin
      go_idle = 1'b1;
      if (q.cmd[5:0] == A_DATA) begin
        d.rdy_n = 1'b1;
      end
      if (q.cmd[5:0] == A_STAT) begin
        d.crc_err = 1'b0;
      end
    end

    // Register writes; mode codes may start a calibration
    if (do_wr) begin
      case (q.cmd[5:0])
        A_MODE: begin
          if (q.cal == CAL_NONE) begin
            if (wv[2:0] == CAL_INT_ZS || wv[2:0] == CAL_SYS_ZS || wv[2:0] == CAL_SYS_FS) begin
              // A calibration on several channels would mix them, so it is refused
              if (CHAN_ONE) begin
                d.cal   = (wv[2:0] == CAL_INT_ZS) ? CAL_IZS :
                          (wv[2:0] == CAL_SYS_ZS) ? CAL_SZS : CAL_SFS;
                d.rdy_n = 1'b1;
              end
            end else begin
              d.mode = wv[2:0];
            end
          end
        end
        A_IFM: begin
          d.contread = wv[IFM_CONTREAD];
          d.crc_sel  = wv[IFM_CRC_LSB +: 2];
        end
        A_OFFS: begin
          if (q.cal != CAL_IZS) begin
            d.offs = wv;
          end
        end
        A_GAIN: begin
          if (q.cal != CAL_IZS) begin
            d.gain = wv;
          end
        end
        default: begin
          d.mode = d.mode;
        end
      endcase
    end

    if (go_idle) begin
      d.st  = d.contread ? P_CRD : P_CMD;
      d.cnt = 6'h00;
      c_clr = 1'b1;
    end

    // New result: ready goes not-ready first, data lands the next cycle
    if (q.upd_pend) begin
      d.data     = acs_scale(acs_corr(q.raw, q.offs, BIPOLAR), q.gain, BIPOLAR);
      d.rdy_n    = 1'b0;
      d.upd_pend = 1'b0;
      if (q.mode == MODE_SINGLE) begin
        d.mode = MODE_STBY;
      end
    end else if (CONV_VALID && q.cal == CAL_NONE && q.mode != MODE_STBY) begin
      d.raw      = CONV_RAW;
      d.upd_pend = 1'b1;
      d.rdy_n    = 1'b1;
    end

    // Full-scale gain is 2^45 over the corrected code, one quotient bit a cycle
    if (q.div_run) begin
      rem_t = {q.rem[24:0], (q.div_i == 6'(DIV_STEPS - 1))};
      if (rem_t >= q.den) begin
        d.rem = rem_t - q.den;
        qb    = 1'b1;
      end else begin
        d.rem = rem_t;
      end
      d.ovf   = q.ovf | q.quo[23];
      d.quo   = {q.quo[22:0], qb};
      d.div_i = q.div_i - 6'h01;
      if (q.div_i == 6'h00) begin
        d.div_run = 1'b0;
        cal_done  = 1'b1;
        if (!d.ovf) begin
          d.gain = d.quo;
        end
      end
    end else if (q.cal != CAL_NONE && CONV_VALID) begin
      // The filter's settled code ends the calibration like a conversion
      if (q.cal == CAL_SFS) begin
        corr = acs_corr(CONV_RAW, q.offs, BIPOLAR);
        if (corr > 0) begin
          d.den     = corr;
          d.rem     = 26'h0000000;
          d.quo     = 24'h000000;
          d.ovf     = 1'b0;
          d.div_i   = 6'(DIV_STEPS - 1);
          d.div_run = 1'b1;
        end else begin
          cal_done = 1'b1; // Unusable code leaves the gain alone
        end
      end else begin
        d.offs   = CONV_RAW + MID_SCALE;
        cal_done = 1'b1;
      end
    end

    if (cal_done) begin
      d.cal   = CAL_NONE;
      d.rdy_n = 1'b0;
      d.mode  = MODE_STBY;
    end

    // Sixty-fourth high bit restores everything but the pin samplers
    if (q.cs_lo && rise && din_b && q.ones == RST_ONES - 7'h01) begin
      d     = ST_INIT;
      c_clr = 1'b1;
    end

    // Pin samplers; only the second and third stages are looked at
    d.sclk_s = {q.sclk_s[1:0], SCLK};
    d.cs_s   = {q.cs_s[1:0], CS_N};
    d.din_s  = {q.din_s[1:0], DIN};
    d.cs_lo  = (q.cs_s[1] == q.cs_s[2]) ? ~q.cs_s[2] : q.cs_lo;
    if (d.st != P_RD && d.st != P_RCRC) begin
      d.dout = d.rdy_n;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      q <= ST_INIT;
    end else begin
      q <= d;
    end
  end

  // Pin and status outputs
  assign DOUT_RDY  = q.dout;
  assign DOUT_OE   = q.cs_lo;
  assign CRC_FAULT = q.crc_err;
  assign IN_SHORT  = (q.cal == CAL_IZS);
  assign CONV_RUN  = (q.cal != CAL_NONE && !q.div_run) ||
                     q.mode == MODE_CONT || q.mode == MODE_SINGLE;
endmodule // acs_top
`default_nettype wire

/* File: testbench/acs_host.sv */
// Host serial master model: clocks frames in MSB first and samples the reply.
// Assumes: clock idles high, chip select tied low (three wires), 64 ns period.
`timescale 1ns/1ps
`default_nettype none
module acs_host (
  output var logic SCLK,
  output var logic CS_N,
  output var logic DIN,
  input wire logic DOUT_RDY
);
  // Data idles low so no run of ones builds up a serial reset
  initial begin
    SCLK = 1'b1;
    CS_N = 1'b0;
    DIN  = 1'b0;
  end
  // Data changes while the clock is low, then drops low after the last rise; reply taken at each rise
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      SCLK = 1'b0;
      DIN  = tx[i];
      #32;
      SCLK = 1'b1;
      rx   = {rx[62:0], DOUT_RDY};
      #32;
    end
    DIN = 1'b0;
    #200;
  endtask
endmodule // acs_host
`default_nettype wire

/* File: testbench/acs_props.sv */
// Checker on the serial port top: ready line, calibration and checksum flag.
// Assumes: one clock domain; bound to acs_top by the statement at the foot.
`timescale 1ns/1ps
`default_nettype none
module acs_props (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        SCLK,
  input wire logic        CS_N,
  input wire logic        DIN,
  input wire logic        DOUT_RDY,
  input wire logic        DOUT_OE,
  input wire logic        BIPOLAR,
  input wire logic        CHAN_ONE,
  input wire logic        CONV_VALID,
  input wire logic [23:0] CONV_RAW,
  input wire logic        CONV_RUN,
  input wire logic        IN_SHORT,
  input wire logic        CRC_FAULT
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  // Clock high longer than a half bit, so no edge is still in the sampler
  sequence s_quiet;
    SCLK [*8];
  endsequence
  // Not-ready now or next cycle, then ready once the new value has landed
  sequence s_update;
    ##[0:1] DOUT_RDY ##[1:60] !DOUT_RDY;
  endsequence
  chk_rst_state: assert property ($fell(RST) |->
    DOUT_RDY && CONV_RUN && !IN_SHORT && !CRC_FAULT) else $error("not in reset state");
  chk_conv_ready: assert property (s_quiet ##0 CONV_VALID && CONV_RUN |-> s_update)
    else $error("ready line missed a result");
  chk_cal_busy: assert property (s_quiet ##0 IN_SHORT |-> DOUT_RDY)
    else $error("ready during internal calibration");
  chk_cal_wait: assert property ($rose(IN_SHORT) |->
    CONV_RUN && CHAN_ONE && $past(CHAN_ONE)) else $error("calibration start wrong");
  chk_cal_cause: assert property ($fell(IN_SHORT) |->
    $past(CONV_VALID) || $past(CONV_VALID, 2)) else $error("calibration ended without code");
  chk_cal_done: assert property ($fell(IN_SHORT) |->
    ##[0:1] (!DOUT_RDY && !CONV_RUN)) else $error("no ready or standby at end");
  chk_fault_hold: assert property (s_quiet ##0 CRC_FAULT |=> CRC_FAULT)
    else $error("fault flag cleared while idle");
  chk_oe_follow: assert property (!CS_N [*6] |-> DOUT_OE)
    else $error("output not enabled while selected");
endmodule // acs_props

bind acs_top acs_props i_props (.CORE_CLK(CORE_CLK), .RST(RST), .SCLK(SCLK), .CS_N(CS_N),
  .DIN(DIN), .DOUT_RDY(DOUT_RDY), .DOUT_OE(DOUT_OE), .BIPOLAR(BIPOLAR), .CHAN_ONE(CHAN_ONE),
  .CONV_VALID(CONV_VALID), .CONV_RAW(CONV_RAW), .CONV_RUN(CONV_RUN), .IN_SHORT(IN_SHORT),
  .CRC_FAULT(CRC_FAULT));
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the converter port with calibration and checksums.
// Assumes: acs_host drives the serial pins; the filter side is driven here.
`timescale 1ns/1ps
`default_nettype none
module tb
  import acs_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        bip;
  logic        one;
  logic        cv;
  logic [23:0] raw;
  logic [23:0] offs;
  logic [23:0] gain;
  logic [63:0] rx;
  logic [23:0] cr [3];
  int          err_total;
  int          n_checks;
  wire         sclk, cs_n, din, dout, oe, run, shrt, fault;

  acs_top i_dut (.CORE_CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .DIN(din),
    .DOUT_RDY(dout), .DOUT_OE(oe), .BIPOLAR(bip), .CHAN_ONE(one), .CONV_VALID(cv),
    .CONV_RAW(raw), .CONV_RUN(run), .IN_SHORT(shrt), .CRC_FAULT(fault));
  acs_host i_host (.SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT_RDY(dout));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask

  // Remainder after MSB-first division by 100000111, zero start value
  function automatic logic [7:0] crc8(input logic [39:0] m, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  function automatic logic [7:0] xsum(input logic [39:0] m);
    return m[39:32] ^ m[31:24] ^ m[23:16] ^ m[15:8] ^ m[7:0];
  endfunction

  // Expected result, clamped to the 24-bit range
  function automatic logic [23:0] scale(input logic [23:0] r, input logic b);
    longint v;
    v = b ? longint'(signed'(r)) : longint'(r);
    v = (v - (longint'(offs) - 64'sh800000)) * longint'(gain);
    v = b ? (v >>> 22) + 64'sh800000 : v >>> 21;
    return (v < 0) ? 24'h000000 : (v > 64'shFFFFFF) ? 24'hFFFFFF : v[23:0];
  endfunction

  // Write frame; ck 1 adds a good checksum byte, 2 a corrupted one
  task automatic wr(input logic [5:0] a, input logic [23:0] d, input int nb, input int ck);
    logic [39:0] m;
    logic [7:0]  c;
    m = (40'({2'b00, a}) << nb) | 40'(d);
    c = crc8(m, nb + 8) ^ ((ck == 2) ? 8'h01 : 8'h00);
    i_host.xfer((ck > 0) ? 64'({m[31:0], c}) : 64'(m), nb + ((ck > 0) ? 16 : 8), rx);
  endtask

  // Read frame; in continuous read the command is implied, not sent
  task automatic rd(input logic [7:0] cmd, input int nb, input logic [1:0] sel,
                    input logic [23:0] d, input logic cont = 1'b0,
                    input logic [39:0] msk = '1);
    logic [39:0] m;
    logic [39:0] e;
    logic [7:0]  c;
    int          k;
    m = (40'(cmd) << nb) | 40'(d);
    c = (sel == CRC_XOR) ? xsum(m) : crc8(m, nb + 8);
    k = nb + ((sel != CRC_OFF) ? 8 : 0);
    e = (sel != CRC_OFF) ? {m[31:0], c} : m;
    i_host.xfer(cont ? 64'h0 : 64'(cmd) << k, cont ? k : k + 8, rx);
    msk = msk & ((40'h1 << k) - 40'h1);
    chk(rx[39:0] & msk, e & msk);
  endtask

  // One filter code; the wait covers the longest full-scale division
  task automatic conv(input logic [23:0] r, input logic b);
    @(posedge clk);
    raw <= r;
    bip <= b;
    cv  <= 1'b1;
    @(posedge clk);
    cv  <= 1'b0;
    repeat (60) @(posedge clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    {rst, bip, one, cv, raw} = {4'b1010, 24'h000000};
    {err_total, n_checks} = {32'd0, 32'd0};
    offs = 24'h800000;
    gain = 24'h555555;
    cr = '{24'h000123, 24'h000010, 24'h400010};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    #7;
    rd(8'h70, 24, CRC_OFF, 24'h800000);
    rd(8'h78, 24, CRC_OFF, 24'h555555);
    // Unipolar then bipolar result, read twice while no update is due
    for (int b = 0; b < 2; b++) begin
      conv(b[0] ? 24'hF00000 : 24'h300000, b[0]);
      chk(40'(dout), 40'h0);
      rd(8'h44, 24, CRC_OFF, scale(raw, b[0]));
      chk(40'(dout), 40'h1);
      rd(8'h44, 24, CRC_OFF, scale(raw, b[0]));
    end
    // Calibration with several channels enabled is refused
    @(posedge clk);
    one <= 1'b0;
    wr(A_MODE, 24'h000004, 16, 0);
    chk(40'(shrt), 40'h0);
    @(posedge clk);
    one <= 1'b1;
    // Offset kinds first, full scale last, as the host must order them
    for (int i = 0; i < 3; i++) begin
      wr(A_MODE, 24'(i + 4), 16, 0);
      chk(40'({dout, shrt, run}), {37'h0, 1'b1, i == 0, 1'b1});
      if (i == 0) begin
        wr(A_OFFS, 24'h123456, 24, 0);
        rd(8'h70, 24, CRC_OFF, offs);
      end
      conv(cr[i], 1'b0);
      chk(40'({dout, shrt, run}), 40'h0);
      if (i < 2) offs = cr[i] + 24'h800000;
      else gain = 24'(64'h200000000000 / 64'(cr[i] - offs + 24'h800000));
      rd((i < 2) ? 8'h70 : 8'h78, 24, CRC_OFF, (i < 2) ? offs : gain);
    end
    // Polynomial checksum: good write, bad write refused, flag until status read
    wr(A_IFM, 24'h000008, 16, 0);
    rd(8'h70, 24, 2'h2, offs);
    wr(A_OFFS, 24'h800000, 24, 1);
    offs = 24'h800000;
    chk(40'(fault), 40'h0);
    wr(A_OFFS, 24'h111111, 24, 2);
    chk(40'(fault), 40'h1);
    rd(8'h70, 24, 2'h2, offs);
    rd(8'h40, 8, 2'h2, 24'h000040, 1'b0, 40'h4000);
    chk(40'(fault), 40'h0);
    wr(A_IFM, 24'h000004, 16, 1);
    rd(8'h78, 24, CRC_XOR, gain);
    // Continuous read of a zero result still carries a nonzero checksum
    wr(A_MODE, 24'h000000, 16, 1);
    conv(24'h000000, 1'b0);
    chk(40'(dout), 40'h0);
    wr(A_IFM, 24'h000088, 16, 1);
    rd(8'h44, 24, 2'h2, scale(24'h000000, 1'b0), 1'b1);
    // The port does not enforce the settling pause, so it is skipped
    i_host.xfer(64'hFFFFFFFFFFFFFFFF, 64, rx);
    rd(8'h70, 24, CRC_OFF, 24'h800000);
    rd(8'h78, 24, CRC_OFF, 24'h555555);
    results();
  end

  // Watchdog: the sequence needs about 70 us
  initial begin
    #400000;
    err_total++;
    results();
  end
endmodule // tb
`default_nettype wire
